/* hbw_defines.svh */
`ifndef HBW_DEFINES_SVH
`define HBW_DEFINES_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define HBW_CLK_PERIOD_NS 40
`define HBW_RD_WAIT_NS 110
`define HBW_WR_WAIT_NS 85
`define HBW_RD_WAIT_CYC ((`HBW_RD_WAIT_NS + `HBW_CLK_PERIOD_NS - 1) / `HBW_CLK_PERIOD_NS)
`define HBW_WR_WAIT_CYC ((`HBW_WR_WAIT_NS + `HBW_CLK_PERIOD_NS - 1) / `HBW_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// Address map (A1-A15 word address)
// ----------------------------------------------------------------
`define HBW_BANK_SEL_ADDR 15'h0007
`define HBW_QUEUE_DATA_ADDR 15'h0001

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define HBW_ADDR_RST 15'h0000
`define HBW_BE_RST 4'hf
`define HBW_DATA_RST 32'h0000_0000

`endif

/* hbw_pkg.sv */
package hbw_pkg;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      HBW_TGT_NONE,
      HBW_TGT_BANK,
      HBW_TGT_QUEUE,
      HBW_TGT_OTHER
   } hbw_target_e;

   typedef enum logic [2:0] {
      HBW_IDLE,
      HBW_RD_WAIT,
      HBW_RD_HOLD,
      HBW_WR_ACTIVE,
      HBW_WR_WAIT
   } hbw_state_e;

   typedef logic [14:0] hbw_addr_t;

endpackage : hbw_pkg

/* hbw_addr_if.sv */
`timescale 1ns/10ps

interface hbw_addr_if;
   import hbw_pkg::*;

   hbw_addr_t addr;
   logic [3:0] byte_lane_enable_n;
   logic selected;
   hbw_target_e target;

   modport latch (output addr, output byte_lane_enable_n, output selected, output target);
   modport core (input addr, input byte_lane_enable_n, input selected, input target);
endinterface : hbw_addr_if

/* hbw_addr_latch.sv */
`timescale 1ns/10ps
`include "hbw_defines.svh"

module hbw_addr_latch (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire hbw_pkg::hbw_addr_t addr_in,
   input wire logic address_qualifier_in,
   input wire logic [3:0] byte_lane_enable_n_in,
   input wire logic address_latch_strobe_n_in,
   input wire logic data_window_select_n_in,
   hbw_addr_if.latch addr_bus
);
   import hbw_pkg::*;

   hbw_addr_t held_addr;
   logic [3:0] held_be_n;
   logic held_qual;
   logic strobe_prev;
   logic strobe_rise;
   hbw_addr_t cur_addr;
   logic cur_qual;

   // ----------------------------------------------------------------
   // Latch on address strobe rising edge
   // ----------------------------------------------------------------
   assign strobe_rise = address_latch_strobe_n_in & ~strobe_prev;

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         strobe_prev <= 1'b0;
      end else begin
         strobe_prev <= address_latch_strobe_n_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         held_addr <= `HBW_ADDR_RST;
         held_be_n <= `HBW_BE_RST;
         held_qual <= 1'b0;
      end else if (strobe_rise) begin
         held_addr <= addr_in;
         held_be_n <= byte_lane_enable_n_in;
         held_qual <= address_qualifier_in;
      end
   end

   // ----------------------------------------------------------------
   // Strobe tied low: address flows through
   // ----------------------------------------------------------------
   always_comb begin
      cur_addr = address_latch_strobe_n_in ? held_addr : addr_in;
      cur_qual = address_latch_strobe_n_in ? held_qual : address_qualifier_in;
      addr_bus.addr = cur_addr;
      addr_bus.byte_lane_enable_n = address_latch_strobe_n_in ? held_be_n : byte_lane_enable_n_in;
      addr_bus.selected = cur_qual | ~data_window_select_n_in;
      if (!data_window_select_n_in) begin
         addr_bus.target = HBW_TGT_QUEUE;
      end else if (!cur_qual) begin
         addr_bus.target = HBW_TGT_NONE;
      end else if (cur_addr == `HBW_BANK_SEL_ADDR) begin
         addr_bus.target = HBW_TGT_BANK;
      end else if (cur_addr == `HBW_QUEUE_DATA_ADDR) begin
         addr_bus.target = HBW_TGT_QUEUE;
      end else begin
         addr_bus.target = HBW_TGT_OTHER;
      end
   end

endmodule : hbw_addr_latch

/* hbw_host_port.sv */
`timescale 1ns/10ps
`include "hbw_defines.svh"

// Summary of operation
// - A new strobe during a trailing wait is accepted and stretched by ready.
// - Bank select read completes without holding ready low.
// - Queue data read holds ready low about 110 ns before data.
// - Bank select write completes without holding ready low.
// - Queue data write holds ready low about 85 ns.
// - Ready drops promptly after read strobe when a wait is needed.
// - Ready drops promptly after write strobe release when a wait is needed.
// - Ready rises on a read once read data is driven, but a cycle before it on a bank read held off by a trailing wait.
// - Address, qualifier, byte enables captured on address strobe rising edge.
// - Data window select picks the queue data window without address decode.
// - Write data is sampled on every clock of a selected write while the write strobe is low; the last sample before release is kept.
module hbw_host_port #(
   parameter int DATA_W = 32,
   parameter int CNT_W = 4
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire hbw_pkg::hbw_addr_t addr_in,
   input wire logic address_qualifier_in,
   input wire logic [3:0] byte_lane_enable_n_in,
   input wire logic address_latch_strobe_n_in,
   input wire logic data_window_select_n_in,
   input wire logic host_read_strobe_n_in,
   input wire logic host_write_strobe_n_in,
   input wire logic [DATA_W-1:0] data_in,
   output logic [DATA_W-1:0] data_out,
   output logic data_oe_out,
   output logic access_ready_out,
   output logic reg_rd_out,
   output logic reg_wr_out,
   output hbw_pkg::hbw_addr_t reg_addr_out,
   output logic [3:0] reg_byte_lane_enable_n_out,
   output logic reg_queue_out,
   output logic [DATA_W-1:0] reg_wdata_out,
   input wire logic [DATA_W-1:0] reg_rdata_in
);
   import hbw_pkg::*;

   localparam logic [CNT_W-1:0] RD_WAIT = CNT_W'(`HBW_RD_WAIT_CYC);
   localparam logic [CNT_W-1:0] WR_WAIT = CNT_W'(`HBW_WR_WAIT_CYC);

   hbw_state_e state;
   hbw_state_e next_state;
   logic [CNT_W-1:0] wait_cnt;
   logic [CNT_W-1:0] next_wait_cnt;
   logic cnt_done;
   logic start_rd;
   logic start_wr;
   logic wr_release;
   logic rd_finish;
   hbw_addr_t acc_addr;
   logic [3:0] acc_be_n;
   logic acc_queue;

   hbw_addr_if addr_bus ();

   // ----------------------------------------------------------------
   // Target decode
   // ----------------------------------------------------------------
   function automatic logic is_queue(input hbw_target_e target);
      return target == HBW_TGT_QUEUE;
   endfunction : is_queue

   // ----------------------------------------------------------------
   // Address capture and decode
   // ----------------------------------------------------------------
   hbw_addr_latch u_latch (
      .core_clk_in(core_clk_in),
      .rstn_in(rstn_in),
      .addr_in(addr_in),
      .address_qualifier_in(address_qualifier_in),
      .byte_lane_enable_n_in(byte_lane_enable_n_in),
      .address_latch_strobe_n_in(address_latch_strobe_n_in),
      .data_window_select_n_in(data_window_select_n_in),
      .addr_bus(addr_bus)
   );

   // ----------------------------------------------------------------
   // Access detection
   // ----------------------------------------------------------------
   assign start_rd = (state == HBW_IDLE) && !host_read_strobe_n_in && addr_bus.selected;
   assign start_wr = (state == HBW_IDLE) && host_read_strobe_n_in && !host_write_strobe_n_in
                     && addr_bus.selected;
   assign wr_release = (state == HBW_WR_ACTIVE) && host_write_strobe_n_in;
   assign cnt_done = (wait_cnt == {CNT_W{1'b0}});
   assign rd_finish = (state == HBW_RD_WAIT) && cnt_done;

   // ----------------------------------------------------------------
   // State machine
   // ----------------------------------------------------------------
   always_comb begin
      next_state = state;
      next_wait_cnt = wait_cnt;
      unique case (state)
         HBW_IDLE: begin
            if (start_rd) begin
               if (is_queue(addr_bus.target)) begin
                  next_state = HBW_RD_WAIT;
                  next_wait_cnt = RD_WAIT - CNT_W'(1);
               end else begin
                  next_state = HBW_RD_HOLD;
               end
            end else if (start_wr) begin
               next_state = HBW_WR_ACTIVE;
            end
         end
         HBW_RD_WAIT: begin
            if (cnt_done) begin
               next_state = HBW_RD_HOLD;
            end else begin
               next_wait_cnt = wait_cnt - CNT_W'(1);
            end
         end
         HBW_RD_HOLD: begin
            if (host_read_strobe_n_in) begin
               next_state = HBW_IDLE;
            end
         end
         HBW_WR_ACTIVE: begin
            if (host_write_strobe_n_in) begin
               if (acc_queue) begin
                  next_state = HBW_WR_WAIT;
                  next_wait_cnt = WR_WAIT - CNT_W'(1);
               end else begin
                  next_state = HBW_IDLE;
               end
            end
         end
         HBW_WR_WAIT: begin
            if (cnt_done) begin
               next_state = HBW_IDLE;
            end else begin
               next_wait_cnt = wait_cnt - CNT_W'(1);
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         state <= HBW_IDLE;
         wait_cnt <= {CNT_W{1'b0}};
      end else begin
         state <= next_state;
         wait_cnt <= next_wait_cnt;
      end
   end

   // ----------------------------------------------------------------
   // Access context held for the whole access
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         acc_addr <= `HBW_ADDR_RST;
         acc_be_n <= `HBW_BE_RST;
         acc_queue <= 1'b0;
      end else if (start_rd || start_wr) begin
         acc_addr <= addr_bus.addr;
         acc_be_n <= addr_bus.byte_lane_enable_n;
         acc_queue <= is_queue(addr_bus.target);
      end
   end

   // ----------------------------------------------------------------
   // Register side strobes
   // ----------------------------------------------------------------
   assign reg_rd_out = (start_rd && !is_queue(addr_bus.target)) || rd_finish;
   assign reg_wr_out = wr_release;
   assign reg_addr_out = (state == HBW_IDLE) ? addr_bus.addr : acc_addr;
   assign reg_byte_lane_enable_n_out = (state == HBW_IDLE) ? addr_bus.byte_lane_enable_n
                                       : acc_be_n;
   assign reg_queue_out = (state == HBW_IDLE) ? is_queue(addr_bus.target) : acc_queue;

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         reg_wdata_out <= `HBW_DATA_RST;
      end else if ((start_wr || state == HBW_WR_ACTIVE) && !host_write_strobe_n_in) begin
         reg_wdata_out <= data_in;
      end
   end

   // ----------------------------------------------------------------
   // Read data and bus drive
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         data_out <= `HBW_DATA_RST;
      end else if (reg_rd_out) begin
         data_out <= reg_rdata_in;
      end
   end

   always_ff @(posedge core_clk_in or negedge rstn_in) begin
      if (!rstn_in) begin
         data_oe_out <= 1'b0;
      end else begin
         data_oe_out <= (next_state == HBW_RD_HOLD);
      end
   end

   // ----------------------------------------------------------------
   // Ready
   // ----------------------------------------------------------------
   always_comb begin
      access_ready_out = 1'b1;
      if (state == HBW_RD_WAIT) begin
         access_ready_out = 1'b0;
      end else if (state == HBW_WR_WAIT) begin
         access_ready_out = 1'b0;
      end else if (start_rd && is_queue(addr_bus.target)) begin
         access_ready_out = 1'b0;
      end else if (wr_release && acc_queue) begin
         access_ready_out = 1'b0;
      end
   end

endmodule : hbw_host_port

/* hbw_host_port_assertions.sv */
`timescale 1ns/10ps

module hbw_host_port_assertions #(
   parameter int DATA_W = 32
) (
   input wire logic core_clk_in,
   input wire logic rstn_in,
   input wire logic host_read_strobe_n_in,
   input wire logic host_write_strobe_n_in,
   input wire logic data_window_select_n_in,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic [DATA_W-1:0] data_out,
   input wire logic data_oe_out,
   input wire logic access_ready_out,
   input wire logic reg_rd_out,
   input wire logic reg_wr_out,
   input wire logic reg_queue_out,
   input wire logic [DATA_W-1:0] reg_wdata_out,
   input wire logic [DATA_W-1:0] reg_rdata_in
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);

   a_bank_rd_nowait: assert property (reg_rd_out && !reg_queue_out |-> access_ready_out)
      else $error("bank read stretched");
   a_bank_wr_nowait: assert property (reg_wr_out && !reg_queue_out |-> access_ready_out)
      else $error("bank write stretched");
   a_queue_rd_wait: assert property (reg_rd_out && reg_queue_out |-> !access_ready_out
      && !$past(access_ready_out, 2) ##1 access_ready_out && data_oe_out)
      else $error("queue read wait wrong");
   a_rd_ready_drop: assert property (
      reg_rd_out && reg_queue_out |-> !$past(access_ready_out, 3))
      else $error("ready not low at read start");
   a_queue_wr_wait: assert property (reg_wr_out && reg_queue_out |->
      !access_ready_out [*3] ##[1:2] access_ready_out)
      else $error("queue write wait wrong");
   a_rd_data_lag: assert property (
      reg_rd_out |=> data_oe_out && data_out == $past(reg_rdata_in))
      else $error("read data not driven");
   a_ready_with_data: assert property ($rose(access_ready_out) && !host_read_strobe_n_in
      && !reg_rd_out |-> data_oe_out)
      else $error("ready rose before data");
   a_wr_on_release: assert property (reg_wr_out |-> host_write_strobe_n_in
      && !$past(host_write_strobe_n_in) && reg_wdata_out == $past(data_in))
      else $error("write not taken at release");
   a_window_queue: assert property (
      reg_rd_out && !data_window_select_n_in |-> reg_queue_out)
      else $error("window select ignored");

   c_queue_rd: cover property (reg_rd_out && reg_queue_out);
   c_queue_wr: cover property (reg_wr_out && reg_queue_out);
   c_bank_rd: cover property (reg_rd_out && !reg_queue_out);
endmodule : hbw_host_port_assertions

bind hbw_host_port hbw_host_port_assertions #(.DATA_W(DATA_W)) i_chk (
   .core_clk_in(core_clk_in),
   .rstn_in(rstn_in),
   .host_read_strobe_n_in(host_read_strobe_n_in),
   .host_write_strobe_n_in(host_write_strobe_n_in),
   .data_window_select_n_in(data_window_select_n_in),
   .data_in(data_in),
   .data_out(data_out),
   .data_oe_out(data_oe_out),
   .access_ready_out(access_ready_out),
   .reg_rd_out(reg_rd_out),
   .reg_wr_out(reg_wr_out),
   .reg_queue_out(reg_queue_out),
   .reg_wdata_out(reg_wdata_out),
   .reg_rdata_in(reg_rdata_in)
);

/* hbw_host_model.sv */
`timescale 1ns/10ps

module hbw_host_model (
   input wire logic clk_in,
   input wire logic ready_in,
   input wire logic oe_in,
   input wire logic [31:0] rdata_in,
   output logic rd_n_out = 1'b1,
   output logic wr_n_out = 1'b1,
   output logic ads_n_out = 1'b0,
   output logic win_n_out = 1'b1,
   output logic qual_out = 1'b0,
   output hbw_pkg::hbw_addr_t addr_out = '0,
   output logic [3:0] be_n_out = 4'hf,
   output logic [31:0] data_out = '0
);
   task automatic access(input logic wr, win_n, qual, lat, input hbw_pkg::hbw_addr_t a,
         input logic [3:0] be, input logic [31:0] d, input bit nowait,
         output logic [31:0] rd, output int w);
      w = 0;
      rd = '0;
      @(posedge clk_in);
      #1 addr_out = a;
      qual_out = qual;
      be_n_out = be;
      win_n_out = win_n;
      data_out = wr ? d : ~data_out;
      if (lat) begin
         ads_n_out = 1'b1;
         @(posedge clk_in);
         #1 addr_out = ~a;
      end
      if (wr) begin
         wr_n_out = 1'b0;
         repeat (2) @(posedge clk_in);
         while (!ready_in) @(posedge clk_in);
         #1 wr_n_out = 1'b1;
         if (!nowait) begin
            @(posedge clk_in);
            while (!ready_in) begin
               w++;
               @(posedge clk_in);
            end
            #1 data_out = ~d;
         end
      end else begin
         rd_n_out = 1'b0;
         do begin
            @(posedge clk_in);
            if (!ready_in) w++;
         end while (!(ready_in && oe_in));
         rd = rdata_in;
         #1 rd_n_out = 1'b1;
      end
      ads_n_out = 1'b0;
   endtask : access
endmodule : hbw_host_model

/* tb.sv */
`timescale 1ns/10ps

module tb;
   import hbw_pkg::*;
   typedef struct {logic wr, win_n, qual; hbw_addr_t a; logic [3:0] be;
      logic [31:0] d; logic q; int w;} hbw_row_s;
   hbw_row_s rows [7] = '{
      '{0, 1, 1, 15'h0007, 4'h0, 32'h0000_0000, 0, 0},
      '{0, 1, 1, 15'h0001, 4'h0, 32'h0000_0000, 1, 3},
      '{1, 1, 1, 15'h0007, 4'h3, 32'h1234_5678, 0, 0},
      '{1, 1, 1, 15'h0001, 4'ha, 32'h9abc_def0, 1, 3},
      '{0, 0, 0, 15'h0003, 4'h0, 32'h0000_0000, 1, 3},
      '{1, 0, 0, 15'h0005, 4'h5, 32'h0f0f_a5a5, 1, 3},
      '{1, 1, 1, 15'h0003, 4'hc, 32'h0000_beef, 0, 0}};
   hbw_row_s r;
   logic clk = 0, rstn = 0, rd_n, wr_n, ads_n, win_n, qual, oe, ready, reg_rd, reg_wr, reg_q, m_q;
   hbw_addr_t addr, reg_addr, m_a;
   logic [3:0] be_n, reg_be, m_be;
   logic [31:0] h_data, d_out, reg_wdata, reg_rdata, m_d, rd;
   int w, pulses = 0, cyc = 0, bad_count = 0, check_count = 0;

   always #20 clk = ~clk;
   assign reg_rdata = reg_q ? 32'hc0de_0001 : {17'h0, reg_addr};

   hbw_host_port i_hbw_host_port (.core_clk_in(clk), .rstn_in(rstn), .addr_in(addr),
      .address_qualifier_in(qual), .byte_lane_enable_n_in(be_n),
      .address_latch_strobe_n_in(ads_n), .data_window_select_n_in(win_n),
      .host_read_strobe_n_in(rd_n), .host_write_strobe_n_in(wr_n), .data_in(h_data),
      .data_out(d_out), .data_oe_out(oe), .access_ready_out(ready), .reg_rd_out(reg_rd),
      .reg_wr_out(reg_wr), .reg_addr_out(reg_addr), .reg_byte_lane_enable_n_out(reg_be),
      .reg_queue_out(reg_q), .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata));

   hbw_host_model i_hbw_host_model (.clk_in(clk), .ready_in(ready), .oe_in(oe),
      .rdata_in(d_out), .rd_n_out(rd_n), .wr_n_out(wr_n), .ads_n_out(ads_n),
      .win_n_out(win_n), .qual_out(qual), .addr_out(addr), .be_n_out(be_n), .data_out(h_data));

   always @(posedge clk) begin
      cyc++;
      if (reg_rd === 1'b1 || reg_wr === 1'b1) begin
         pulses++;
         {m_a, m_q, m_be, m_d} = {reg_addr, reg_q, reg_be, reg_wdata};
      end
      if (cyc == 3000) begin
         bad_count++;
         end_sim();
      end
   end

   task chk(input string n, input logic [31:0] e, s);
      check_count++;
      if (s !== e) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", n, e, s);
      end
   endtask : chk

   task end_sim;
      $display("checks %0d mismatches %0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim

   initial begin
      repeat (8) @(posedge clk);
      chk("reset ready", 1, ready);
      chk("reset oe", 0, oe);
      chk("reset rd", 0, reg_rd);
      chk("reset wr", 0, reg_wr);
      chk("reset wdata", 0, reg_wdata);
      chk("reset data", 0, d_out);
      #1 rstn = 1;
      foreach (rows[i]) begin
         r = rows[i];
         pulses = 0;
         i_hbw_host_model.access(r.wr, r.win_n, r.qual, 0, r.a, r.be, r.d, 0, rd, w);
         repeat (2) @(posedge clk);
         chk("pulses", 1, pulses);
         chk("queue", r.q, m_q);
         chk("wait", 1, 32'(w >= r.w && w <= r.w + (r.w != 0)));
         if (r.wr) chk("wdata", r.d, m_d);
         else chk("rdata", r.q ? 32'hc0de_0001 : {17'h0, r.a}, rd);
         if (r.wr) chk("be", r.be, m_be);
      end
      i_hbw_host_model.access(0, 1, 1, 1, 15'h0007, 4'h0, 0, 0, rd, w);
      chk("latched addr", 15'h0007, m_a);
      chk("latched rdata", 32'h0000_0007, rd);
      pulses = 0;
      i_hbw_host_model.access(1, 1, 0, 0, 15'h0001, 4'h0, 32'h5555_0000, 0, rd, w);
      chk("unselected pulses", 0, pulses);
      i_hbw_host_model.access(1, 1, 1, 0, 15'h0001, 4'h0, 32'h7777_1111, 1, rd, w);
      i_hbw_host_model.access(0, 1, 1, 0, 15'h0007, 4'h0, 0, 0, rd, w);
      @(posedge clk);
      chk("b2b pulses", 2, pulses);
      chk("b2b rdata", 32'h0000_0007, rd);
      chk("b2b stretched", 1, 32'(w >= 3));
      end_sim();
   end
endmodule : tb
